// file: aodc_regs.sv
/*
 Configuration bank for output formatting and the processing path, with
 the serial write port, sample latency line and two formatted channels.
 Assumes samples, pins and the serial port are synchronous to clk_in; the
 filter datapath outside consumes the control outputs and returns dsp_*.
*/
`timescale 1ns/1ps
module aodc_regs #(
    parameter int DW = aodc_pkg::DW
) (
    input  wire logic          clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          sen_n_in,
    input  wire logic          sclk_in,
    input  wire logic          sdata_in,
    input  wire logic          pin_lvds_in,
    input  wire logic [2:0]    pin_pdn_in,
    input  wire logic [DW-1:0] raw_a_in,
    input  wire logic [DW-1:0] raw_b_in,
    input  wire logic [DW-1:0] dsp_a_in,
    input  wire logic [DW-1:0] dsp_b_in,
    output logic [DW-1:0]      data_a_out,
    output logic [DW-1:0]      data_b_out,
    output logic [DW/2-1:0]    rise_a_out,
    output logic [DW/2-1:0]    fall_a_out,
    output logic [DW/2-1:0]    rise_b_out,
    output logic [DW/2-1:0]    fall_b_out,
    output logic               lvds_sel_out,
    output logic [2:0]         pdn_mode_out,
    output logic               low_latency_out,
    output logic [3:0]         fine_gain_out,
    output logic [3:0]         gain_corr_out,
    output logic [4:0]         offset_avg_length_out,
    output logic               offset_en_out,
    output logic [2:0]         decim_rate_out,
    output logic               filter_en_out,
    output logic               coef_user_out,
    output logic [4:0]         tap_count_out
);
    // ==========================================
    // Reset release
    logic rst_meta_ff;
    logic rst_n;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // ==========================================
    // Serial writes
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    aodc_serial u_serial (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .sen_n_in    (sen_n_in),
        .sclk_in     (sclk_in),
        .sdata_in    (sdata_in),
        .wr_stb_out  (wr_stb),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data)
    );

    // ==========================================
    // Register bank
    logic [7:0] ctrl_ff;
    logic [7:0] fmt_ff;
    logic [7:0] gain_ff;
    logic [7:0] clo_ff;
    logic [7:0] chi_ff;
    logic [7:0] trim_ff;
    logic [7:0] filt_ff;

    wire wr_ctrl = wr_stb && wr_addr == aodc_pkg::ADDR_CTRL;
    wire wr_fmt  = wr_stb && wr_addr == aodc_pkg::ADDR_FMT;
    wire wr_gain = wr_stb && wr_addr == aodc_pkg::ADDR_GAIN;
    wire wr_clo  = wr_stb && wr_addr == aodc_pkg::ADDR_CLO;
    wire wr_chi  = wr_stb && wr_addr == aodc_pkg::ADDR_CHI;
    wire wr_trim = wr_stb && wr_addr == aodc_pkg::ADDR_TRIM;
    wire wr_filt = wr_stb && wr_addr == aodc_pkg::ADDR_FILT;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= aodc_pkg::REG_RESET;
            fmt_ff <= aodc_pkg::REG_RESET;
            gain_ff <= aodc_pkg::REG_RESET;
            clo_ff <= aodc_pkg::REG_RESET;
            chi_ff <= aodc_pkg::REG_RESET;
            trim_ff <= aodc_pkg::REG_RESET;
            filt_ff <= aodc_pkg::REG_RESET;
        end else begin
            if (wr_ctrl) ctrl_ff <= wr_data;
            if (wr_fmt) fmt_ff <= wr_data;
            if (wr_gain) gain_ff <= wr_data;
            if (wr_clo) clo_ff <= wr_data;
            if (wr_chi) chi_ff <= wr_data & aodc_pkg::CHI_MASK;
            if (wr_trim) trim_ff <= wr_data;
            if (wr_filt) filt_ff <= wr_data;
        end
    end

    // ==========================================
    // Control decode
    wire       ovr = ctrl_ff[aodc_pkg::CTRL_OVR_BIT];
    wire       low_lat = trim_ff[aodc_pkg::TRIM_LL_BIT];
    wire [2:0] decim = filt_ff[2:0];
    wire [2:0] tc_code = trim_ff[aodc_pkg::TRIM_TC_LSB +: 3];
    // Built-in coefficients only exist for decimate by two and four
    wire builtin_ok = decim == aodc_pkg::DEC_BY2 || decim == aodc_pkg::DEC_BY4;
    wire nxt_coef_user = filt_ff[aodc_pkg::FILT_USER_BIT] | ~builtin_ok;
    wire nxt_lvds = ovr ? ctrl_ff[aodc_pkg::CTRL_LVDS_BIT] : pin_lvds_in;
    wire [2:0] nxt_pdn = ovr ? ctrl_ff[2:0] : pin_pdn_in;
    wire [4:0] nxt_taps = filt_ff[aodc_pkg::FILT_ODD_BIT] ? aodc_pkg::TAPS_ODD : aodc_pkg::TAPS_EVEN;
    // Constant so the asynchronous reset branch stays a plain value
    localparam logic [4:0] TC_AT_RESET = aodc_pkg::tc_log2(3'h0);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            lvds_sel_out <= 1'b0;
            pdn_mode_out <= 3'h0;
            low_latency_out <= 1'b0;
            fine_gain_out <= 4'h0;
            gain_corr_out <= 4'h0;
            offset_avg_length_out <= TC_AT_RESET;
            offset_en_out <= 1'b0;
            decim_rate_out <= 3'h0;
            filter_en_out <= 1'b0;
            coef_user_out <= 1'b0;
            tap_count_out <= aodc_pkg::TAPS_EVEN;
        end else begin
            lvds_sel_out <= nxt_lvds;
            pdn_mode_out <= nxt_pdn;
            low_latency_out <= low_lat;
            fine_gain_out <= gain_ff[3:0];
            gain_corr_out <= trim_ff[3:0];
            offset_avg_length_out <= aodc_pkg::tc_log2(tc_code);
            offset_en_out <= filt_ff[aodc_pkg::FILT_OFS_BIT];
            decim_rate_out <= decim;
            // Processing block is held off while it is bypassed
            filter_en_out <= filt_ff[aodc_pkg::FILT_EN_BIT] & ~low_lat;
            coef_user_out <= nxt_coef_user;
            tap_count_out <= nxt_taps;
        end
    end

    // ==========================================
    // Latency line: formatter adds the last stage
    localparam int DEPTH = aodc_pkg::LAT_NORMAL - 1;
    logic [DW-1:0] dly_a_ff [DEPTH];
    logic [DW-1:0] dly_b_ff [DEPTH];
    logic [DW-1:0] ramp_ff;
    logic          toggle_ff;

    // Bypass takes raw samples around the processing block
    wire [DW-1:0] src_a = low_lat ? raw_a_in : dsp_a_in;
    wire [DW-1:0] src_b = low_lat ? raw_b_in : dsp_b_in;
    wire [DW-1:0] tap_a = low_lat ? dly_a_ff[aodc_pkg::LAT_LOW-2] : dly_a_ff[aodc_pkg::LAT_NORMAL-2];
    wire [DW-1:0] tap_b = low_lat ? dly_b_ff[aodc_pkg::LAT_LOW-2] : dly_b_ff[aodc_pkg::LAT_NORMAL-2];
    wire [DW-1:0] custom = {chi_ff[DW-9:0], clo_ff};

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                dly_a_ff[i] <= '0;
                dly_b_ff[i] <= '0;
            end
            ramp_ff <= '0;
            toggle_ff <= 1'b0;
        end else begin
            dly_a_ff[0] <= src_a;
            dly_b_ff[0] <= src_b;
            for (int i = 1; i < DEPTH; i++) begin
                dly_a_ff[i] <= dly_a_ff[i-1];
                dly_b_ff[i] <= dly_b_ff[i-1];
            end
            ramp_ff <= ramp_ff + 1'b1;
            toggle_ff <= ~toggle_ff;
        end
    end

    // ==========================================
    // Output formatting, one instance per channel
    aodc_fmt #(.DW(DW)) u_fmt_a (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .sample_in  (tap_a),
        .pattern_in (fmt_ff[2:0]),
        .bin_in     (fmt_ff[aodc_pkg::FMT_BIN_BIT]),
        .byte_in    (fmt_ff[aodc_pkg::FMT_BYTE_BIT]),
        .custom_in  (custom),
        .ramp_in    (ramp_ff),
        .toggle_in  (toggle_ff),
        .data_out   (data_a_out),
        .rise_out   (rise_a_out),
        .fall_out   (fall_a_out)
    );

    aodc_fmt #(.DW(DW)) u_fmt_b (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .sample_in  (tap_b),
        .pattern_in (fmt_ff[2:0]),
        .bin_in     (fmt_ff[aodc_pkg::FMT_BIN_BIT]),
        .byte_in    (fmt_ff[aodc_pkg::FMT_BYTE_BIT]),
        .custom_in  (custom),
        .ramp_in    (ramp_ff),
        .toggle_in  (toggle_ff),
        .data_out   (data_b_out),
        .rise_out   (rise_b_out),
        .fall_out   (fall_b_out)
    );

    // ==========================================
    // Checks
    logic [3:0] quiet_ff;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            quiet_ff <= 4'h0;
        end else if (wr_stb) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hF) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end

    wire settled_bin = quiet_ff == 4'hF && fmt_ff[2:0] == aodc_pkg::PAT_NORMAL && fmt_ff[aodc_pkg::FMT_BIN_BIT];

    lat_normal_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        settled_bin && !low_lat |-> data_a_out == $past(dsp_a_in, 14))
        else $error("normal latency not 14 cycles");
    lat_low_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        settled_bin && low_lat |-> data_b_out == $past(raw_b_in, 10))
        else $error("low latency not 10 raw cycles");
    pat_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        fmt_ff[2:0] == aodc_pkg::PAT_ZEROS |=> data_a_out == '0 && data_b_out == '0)
        else $error("zero pattern not driven");
    pat_custom_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        fmt_ff[2:0] == aodc_pkg::PAT_CUSTOM |=> data_a_out == {$past(chi_ff[5:0]), $past(clo_ff)})
        else $error("custom pattern mismatch");
    chi_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wr_chi |=> chi_ff[7:6] == 2'h0 && chi_ff[5:0] == $past(wr_data[5:0]))
        else $error("custom high bits wrong");
    gain_wr_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wr_gain |=> ##1 fine_gain_out == $past(wr_data[3:0], 2))
        else $error("fine gain not applied");
    coef_force_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        (decim == aodc_pkg::DEC_NONE || decim == aodc_pkg::DEC_BY8) |=> coef_user_out)
        else $error("built-in coefficients not blocked");
    coef_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        builtin_ok |=> coef_user_out == $past(filt_ff[aodc_pkg::FILT_USER_BIT]))
        else $error("coefficient source wrong");
    ovr_pins_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        !ovr |=> pdn_mode_out == $past(pin_pdn_in) && lvds_sel_out == $past(pin_lvds_in))
        else $error("pins not in charge");
    ovr_regs_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        ovr |=> pdn_mode_out == $past(ctrl_ff[2:0]))
        else $error("register power-down not applied");
    tc_map_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        tc_code == 3'h3 |=> offset_avg_length_out == 5'h18)
        else $error("offset averaging length wrong");
    taps_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        filt_ff[aodc_pkg::FILT_ODD_BIT] |=> tap_count_out == aodc_pkg::TAPS_ODD)
        else $error("odd tap count wrong");

    // ==========================================
    // Control output checks and the ones pattern check
    corr_wr_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wr_trim |=> ##1 gain_corr_out == $past(wr_data[3:0], 2))
        else $error("gain correction not applied");
    dec8_user_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        decim == aodc_pkg::DEC_BY8 |=> coef_user_out)
        else $error("decimate by eight without user coefficients");
    filt_on_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        !low_lat |=> filter_en_out == $past(filt_ff[aodc_pkg::FILT_EN_BIT]))
        else $error("filter enable not applied");
    bypass_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        low_lat |=> !filter_en_out && low_latency_out)
        else $error("processing not bypassed");
    builtin_dec_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        builtin_ok && !filt_ff[aodc_pkg::FILT_USER_BIT] |=> !coef_user_out)
        else $error("built-in coefficients refused");
    lvds_regs_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        ovr |=> lvds_sel_out == $past(ctrl_ff[aodc_pkg::CTRL_LVDS_BIT]))
        else $error("register interface select not applied");
    taps_even_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        !filt_ff[aodc_pkg::FILT_ODD_BIT] |=> tap_count_out == aodc_pkg::TAPS_EVEN)
        else $error("even tap count wrong");
    tc_dflt_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        tc_code[2:1] == 2'h3 |=> offset_avg_length_out == 5'h1B)
        else $error("default averaging length wrong");
    pat_ones_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        fmt_ff[2:0] == aodc_pkg::PAT_ONES |=> data_a_out == '1 && data_b_out == '1)
        else $error("ones pattern not driven");
endmodule

// file: aodc_pkg.sv
/*
 Constants for the output formatting and processing configuration bank:
 register addresses, field positions, reset values, codes and latencies.
 Assumes a single sample clock and an 8-bit address, 8-bit data write frame.
*/
// Function
// - Three-bit selector substitutes test patterns for samples
// - Custom pattern low byte from register 18
// - Custom pattern top six bits from register 19
// - Bit-wise DDR: odd bits rise, even fall
// - Byte-wise DDR: low seven bits rise first
// - Format bit: zero twos complement, one offset
// - Fine gain 0 to 6 dB, half-dB steps
// - Gain correction 0.05 dB steps, both channels
// - Offset time constant code maps averaging length
// - Normal latency is fourteen sample clocks
// - Low latency ten clocks, processing bypassed
// - Decimate by two or four: either coefficients
// - No decimation forces user coefficients
// - Decimate by eight forces user coefficients
// - Tap setting picks 24 even or 23 odd
// - Override bit hands control to registers
// - Override lets register interface, power-down win
// - Coefficient source: zero built-in, one user
package aodc_pkg;
    localparam int DW = 14;
    localparam int FRAME_BITS = 16;
    localparam int LAT_NORMAL = 14;
    localparam int LAT_LOW = 10;

    // ==========================================
    // Register addresses, register reset value and custom high mask
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_FMT  = 8'h16;
    localparam logic [7:0] ADDR_GAIN = 8'h17;
    localparam logic [7:0] ADDR_CLO  = 8'h18;
    localparam logic [7:0] ADDR_CHI  = 8'h19;
    localparam logic [7:0] ADDR_TRIM = 8'h1A;
    localparam logic [7:0] ADDR_FILT = 8'h1B;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CHI_MASK  = 8'h3F;

    // ==========================================
    // Field positions
    localparam int CTRL_OVR_BIT  = 7;
    localparam int CTRL_LVDS_BIT = 5;
    localparam int FMT_BYTE_BIT  = 3;
    localparam int FMT_BIN_BIT   = 4;
    localparam int TRIM_LL_BIT   = 7;
    localparam int TRIM_TC_LSB   = 4;
    localparam int FILT_OFS_BIT  = 7;
    localparam int FILT_USER_BIT = 5;
    localparam int FILT_EN_BIT   = 4;
    localparam int FILT_ODD_BIT  = 3;

    // ==========================================
    // Codes
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'h0,
        PAT_ZEROS  = 3'h1,
        PAT_ONES   = 3'h2,
        PAT_TOGGLE = 3'h3,
        PAT_RAMP   = 3'h4,
        PAT_CUSTOM = 3'h5
    } aodc_pat_t;

    localparam logic [2:0] DEC_BY2  = 3'h0;
    localparam logic [2:0] DEC_BY4  = 3'h1;
    localparam logic [2:0] DEC_NONE = 3'h2;
    localparam logic [2:0] DEC_BY8  = 3'h3;

    localparam logic [DW-1:0] TOGGLE_A = 14'h1555;
    localparam logic [DW-1:0] TOGGLE_B = 14'h2AAA;
    localparam logic [4:0] TAPS_EVEN = 5'h18;
    localparam logic [4:0] TAPS_ODD  = 5'h17;

    // Offset averaging length as a power of two
    function automatic logic [4:0] tc_log2(input logic [2:0] code);
        case (code)
            3'h1: tc_log2 = 5'h1A;
            3'h2: tc_log2 = 5'h19;
            3'h3: tc_log2 = 5'h18;
            3'h4: tc_log2 = 5'h1C;
            3'h5: tc_log2 = 5'h1D;
            default: tc_log2 = 5'h1B;
        endcase
    endfunction
endpackage

// file: aodc_serial.sv
/*
 Serial write port: 16-bit frames, address then data, MSB first.
 Assumes enable, clock and data pins are synchronous to clk_in.
*/
`timescale 1ns/1ps
module aodc_serial (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       sen_n_in,
    input  wire logic       sclk_in,
    input  wire logic       sdata_in,
    output logic            wr_stb_out,
    output logic [7:0]      wr_addr_out,
    output logic [7:0]      wr_data_out
);
    logic        sclk_ff;
    logic [4:0]  cnt_ff;
    logic [15:0] shift_ff;
    wire         rise = sclk_in & ~sclk_ff & ~sen_n_in;
    wire  [15:0] nxt_shift = {shift_ff[14:0], sdata_in};
    wire         last = (cnt_ff == 5'(aodc_pkg::FRAME_BITS - 1));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_ff <= 1'b0;
            cnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
            wr_stb_out <= 1'b0;
            wr_addr_out <= 8'h00;
            wr_data_out <= 8'h00;
        end else begin
            sclk_ff <= sclk_in;
            wr_stb_out <= rise & last;
            // Frame aborts cleanly when enable rises early
            if (sen_n_in) begin
                cnt_ff <= 5'h00;
            end else if (rise) begin
                shift_ff <= nxt_shift;
                cnt_ff <= last ? 5'h00 : cnt_ff + 5'h01;
            end
            if (rise & last) begin
                wr_addr_out <= nxt_shift[15:8];
                wr_data_out <= nxt_shift[7:0];
            end
        end
    end
endmodule

// file: aodc_fmt.sv
/*
 One channel of output formatting: pattern substitution, encoding and
 DDR bit split. Assumes samples arrive in offset binary.
*/
`timescale 1ns/1ps
module aodc_fmt #(
    parameter int DW = aodc_pkg::DW
) (
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic [DW-1:0] sample_in,
    input  wire logic [2:0]    pattern_in,
    input  wire logic          bin_in,
    input  wire logic          byte_in,
    input  wire logic [DW-1:0] custom_in,
    input  wire logic [DW-1:0] ramp_in,
    input  wire logic          toggle_in,
    output logic [DW-1:0]      data_out,
    output logic [DW/2-1:0]    rise_out,
    output logic [DW/2-1:0]    fall_out
);
    logic [DW-1:0]   word;
    logic [DW/2-1:0] odd_bits;
    logic [DW/2-1:0] even_bits;

    // Twos complement is offset binary with the sign inverted
    wire [DW-1:0] coded = {sample_in[DW-1] ^ ~bin_in, sample_in[DW-2:0]};

    always_comb begin
        unique case (pattern_in)
            aodc_pkg::PAT_NORMAL: word = coded;
            aodc_pkg::PAT_ZEROS:  word = '0;
            aodc_pkg::PAT_ONES:   word = '1;
            aodc_pkg::PAT_TOGGLE: word = toggle_in ? aodc_pkg::TOGGLE_B : aodc_pkg::TOGGLE_A;
            aodc_pkg::PAT_RAMP:   word = ramp_in;
            aodc_pkg::PAT_CUSTOM: word = custom_in;
            default:              word = coded;
        endcase
    end

    always_comb begin
        for (int i = 0; i < DW/2; i++) begin
            odd_bits[i] = word[2*i+1];
            even_bits[i] = word[2*i];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= '0;
            rise_out <= '0;
            fall_out <= '0;
        end else begin
            data_out <= word;
            rise_out <= byte_in ? word[DW/2-1:0] : odd_bits;
            fall_out <= byte_in ? word[DW-1:DW/2] : even_bits;
        end
    end

    ddr_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !$past(byte_in) |-> rise_out[0] == data_out[1] && fall_out[DW/2-1] == data_out[DW-2])
        else $error("bit-wise DDR split wrong");
    ddr_byte_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(byte_in) |-> rise_out == data_out[DW/2-1:0] && fall_out == data_out[DW-1:DW/2])
        else $error("byte-wise DDR split wrong");
    fmt_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pattern_in == aodc_pkg::PAT_NORMAL |=>
            data_out == {$past(sample_in[DW-1]) ^ ~$past(bin_in), $past(sample_in[DW-2:0])})
        else $error("data format encoding wrong");
endmodule

// file: aodc_host.sv
/*
 Host-side serial programmer model for the configuration bank.
 Assumes one caller at a time and that every pin moves just after clk_in rises.
*/
`timescale 1ns/1ps
module aodc_host (
    input  wire logic clk_in,
    output logic      sen_n_out,
    output logic      sclk_out,
    output logic      sdata_out
);
    // ==========================================
    // Frame driver
    initial begin
        sen_n_out = 1'b1;
        sclk_out  = 1'b0;
        sdata_out = 1'b0;
    end

    // Fewer than 16 bits raises enable early, so the frame is aborted
    task automatic send(input logic [7:0] a, input logic [7:0] d, input int nbits);
        logic [15:0] f;
        f = {a, d};
        for (int i = 15; i >= 16 - nbits; i--) begin
            @(posedge clk_in);
            sen_n_out <= 1'b0;
            sclk_out  <= 1'b0;
            sdata_out <= f[i];
            @(posedge clk_in);
            sclk_out  <= 1'b1;
        end
        @(posedge clk_in);
        sclk_out  <= 1'b0;
        sen_n_out <= 1'b1;
        // Released line must not keep showing the last bit
        sdata_out <= ~sdata_out;
    endtask
endmodule

// file: aodc_tb.sv
/*
 Self-checking bench for the configuration bank, with the host model.
 Assumes the fixed three-edge write-to-output delay and sample latencies.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module tb;
    // ==========================================
    // Signals
    logic        clk_in;
    logic        reset_n_in = 1'b0;
    logic        pin_lvds   = 1'b0;
    logic [2:0]  pin_pdn    = 3'h0;
    logic [13:0] raw_a = 14'h0000, raw_b = 14'h0000, dsp_a = 14'h0000, dsp_b = 14'h0000;
    logic        sen_n, sclk, sdata;
    logic [13:0] data_a, data_b;
    logic [6:0]  rise_a, fall_a, rise_b, fall_b;
    logic        lvds_sel, low_lat, filter_en, coef_user, offset_en;
    logic [2:0]  pdn_mode, decim;
    logic [3:0]  fine_gain, gain_corr;
    logic [4:0]  offset_avg, tap_count;
    int          cnt = 0;
    int          err_count = 0;
    int          cmp_count = 0;

    aodc_host HOST (.clk_in(clk_in), .sen_n_out(sen_n), .sclk_out(sclk), .sdata_out(sdata));

    aodc_regs DUT (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .sen_n_in(sen_n), .sclk_in(sclk), .sdata_in(sdata),
        .pin_lvds_in(pin_lvds), .pin_pdn_in(pin_pdn), .raw_a_in(raw_a), .raw_b_in(raw_b),
        .dsp_a_in(dsp_a), .dsp_b_in(dsp_b), .data_a_out(data_a), .data_b_out(data_b),
        .rise_a_out(rise_a), .fall_a_out(fall_a), .rise_b_out(rise_b), .fall_b_out(fall_b),
        .lvds_sel_out(lvds_sel), .pdn_mode_out(pdn_mode), .low_latency_out(low_lat),
        .fine_gain_out(fine_gain), .gain_corr_out(gain_corr), .offset_avg_length_out(offset_avg),
        .offset_en_out(offset_en), .decim_rate_out(decim), .filter_en_out(filter_en),
        .coef_user_out(coef_user), .tap_count_out(tap_count)
    );

    // ==========================================
    // Clock and sample sources
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Distinct slope per source, so a wrong path or latency shows
    function automatic logic [13:0] smp(input int k, input int c);
        smp = 14'(k * c);
    endfunction

    always @(posedge clk_in) begin
        cnt   <= cnt + 1;
        raw_a <= smp(5, cnt);
        raw_b <= smp(7, cnt);
        dsp_a <= smp(11, cnt);
        dsp_b <= smp(13, cnt);
    end

    // ==========================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        HOST.send(a, d, 16);
        tick(5);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        `CHK(fine_gain, 4'h0)
        `CHK(gain_corr, 4'h0)
        `CHK(offset_avg, 5'h1B)
        `CHK(tap_count, 5'h18)
        `CHK(coef_user, 1'b0)
        `CHK(lvds_sel, 1'b0)
    endtask

    task automatic t_abort();
        HOST.send(8'h17, 8'h05, 9);
        wr(8'h20, 8'h07);
        `CHK(fine_gain, 4'h0)
        wr(8'h17, 8'h0C);
        `CHK(fine_gain, 4'hC)
    endtask

    task automatic t_trim();
        logic [4:0] lg [8] = '{5'h1B, 5'h1A, 5'h19, 5'h18, 5'h1C, 5'h1D, 5'h1B, 5'h1B};
        for (int c = 0; c < 8; c++) begin
            wr(8'h1A, {1'b0, 3'(c), 4'hA});
            `CHK(offset_avg, lg[c])
            `CHK(gain_corr, 4'hA)
        end
    endtask

    task automatic t_path();
        wr(8'h16, 8'h10);
        `CHK(data_a, smp(11, cnt - 15))
        `CHK(data_b, smp(13, cnt - 15))
        // Quiet time lets the latency assertions engage
        tick(14);
        wr(8'h1A, 8'h80);
        // Short path refills ten edges after the switch
        tick(8);
        `CHK(data_a, smp(5, cnt - 11))
        `CHK(low_lat, 1'b1)
        tick(8);
        wr(8'h16, 8'h00);
        `CHK(data_a, smp(5, cnt - 11) ^ 14'h2000)
        wr(8'h1B, 8'h10);
        `CHK(filter_en, 1'b0)
        wr(8'h1A, 8'h00);
        `CHK(filter_en, 1'b1)
        // Normal path needs fourteen edges to refill
        tick(12);
        `CHK(data_a, smp(11, cnt - 15) ^ 14'h2000)
    endtask

    task automatic t_pat();
        logic [13:0] d1;
        wr(8'h16, 8'h01);
        `CHK(data_a, 14'h0000)
        wr(8'h16, 8'h02);
        `CHK(data_b, 14'h3FFF)
        wr(8'h16, 8'h03);
        d1 = data_a;
        tick(1);
        `CHK(d1 ^ data_a, 14'h3FFF)
        `CHK(d1 == 14'h1555 || d1 == 14'h2AAA, 1'b1)
        wr(8'h16, 8'h04);
        d1 = data_a;
        tick(1);
        `CHK(data_a, 14'(d1 + 14'h0001))
        wr(8'h18, 8'hA5);
        wr(8'h19, 8'h2B);
        wr(8'h16, 8'h05);
        `CHK(data_b, 14'h2BA5)
        `CHK(rise_a, 7'h7C)
        `CHK(fall_a, 7'h13)
        wr(8'h16, 8'h0D);
        `CHK(rise_b, 7'h25)
        `CHK(fall_b, 7'h57)
    endtask

    task automatic t_filt();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? (8'h98 | 8'(i)) : (8'h20 | 8'(i - 4));
            wr(8'h1B, v);
            `CHK(decim, v[2:0])
            `CHK(coef_user, v[5] | v[1])
            `CHK(filter_en, v[4])
            `CHK(tap_count, v[3] ? 5'h17 : 5'h18)
            `CHK(offset_en, v[7])
        end
    endtask

    task automatic t_ovr();
        @(posedge clk_in);
        pin_lvds <= 1'b1;
        pin_pdn  <= 3'h5;
        tick(3);
        `CHK(pdn_mode, 3'h5)
        wr(8'h14, 8'h82);
        `CHK(lvds_sel, 1'b0)
        `CHK(pdn_mode, 3'h2)
        wr(8'h14, 8'h02);
        `CHK(lvds_sel, 1'b1)
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        tick(3);
        t_reset();
        t_abort();
        t_trim();
        t_path();
        t_pat();
        t_filt();
        t_ovr();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        finish_test();
    end
endmodule
